/* File: acsr_pkg.sv */
/*
 * constants for the converter slot select and result register block.
 * assumes a 24-bit register port with 6-bit register numbers (spi/i2c front end outside).
 */
// ----------------------------------------------------------------------
// Overview of operation
// - four-bit channel select for slot six at bits 0 to 3.
// - four-bit channel select for slot seven at bits 4 to 7.
// - touch action codes: 00 dummy discharge, 01 X, 10 Y, 11 contact.
// - slot zero touch action at bits 8-9, slots one to six follow pairwise.
// - slot seven touch action at bits 22-23, same encoding.
// - first result, ten bits at 2 to 11 of result register a.
// - second result, ten bits at 14 to 23 of result register a.
// - third result, ten bits at 2 to 11 of result register b.
// - fourth result, ten bits at 14 to 23 of result register b.
// ----------------------------------------------------------------------
package acsr_pkg;
   localparam int REG_W = 24;
   localparam int ADDR_W = 6;
   localparam int RES_W = 10;
   localparam int CHAN_W = 4;
   localparam int TACT_W = 2;
   localparam int SLOTS = 8;
   localparam int RESULTS = 4;
   localparam logic [5:0] ADDR_SLOT_SELECT = 6'h2E;
   localparam logic [5:0] ADDR_RESULT_A = 6'h2F;
   localparam logic [5:0] ADDR_RESULT_B = 6'h30;
   localparam int SEL6_LSB = 0;
   localparam int SEL7_LSB = 4;
   localparam int TACT0_LSB = 8;
   localparam int RES_LO_LSB = 2;
   localparam int RES_HI_LSB = 14;
   localparam logic [23:0] RESET_VALUE = 24'h000000;
   typedef enum logic [1:0] {
      ACSR_TOUCH_DUMMY = 2'h0,
      ACSR_TOUCH_X = 2'h1,
      ACSR_TOUCH_Y = 2'h2,
      ACSR_TOUCH_CONTACT = 2'h3
   } acsr_touch_t;
endpackage

/* File: acsr_result_store.sv */
/*
 * four-entry store of conversion results, registered read data.
 * assumes the converter core gives a one-cycle strobe with slot index and value.
 */
`timescale 1ns/100ps
module acsr_result_store #(
   parameter int DEPTH = 4,
   parameter int WIDTH = 10
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // write from converter
   input wire logic wr_en,
   input wire logic [1:0] wr_idx,
   input wire logic [WIDTH-1:0] wr_data,
   // all entries, registered
   output logic [DEPTH*WIDTH-1:0] rd_all
);
   typedef struct packed {
      logic [DEPTH*WIDTH-1:0] mem;
   } acsr_store_t;
   acsr_store_t state;
   acsr_store_t next_state;

   // only the converter writes here; bus writes never reach it
   always_comb begin
      next_state = state;
      if (wr_en) begin
         next_state.mem[wr_idx*WIDTH +: WIDTH] = wr_data;
      end
   end

   // clears on digital reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign rd_all = state.mem;
endmodule

/* File: acsr_top.sv */
/*
 * slot selection and result registers of the converter sequencer.
 * assumes a register port giving address, write strobe, write data and a read strobe;
 * read data are registered and valid the cycle after the read strobe.
 */
`timescale 1ns/100ps
module acsr_touch_decode (
   // decode input
   input wire logic [1:0] action,
   // decoded one-hot action
   output logic [3:0] onehot
);
   // four-way action encoding
   always_comb begin
      case (acsr_pkg::acsr_touch_t'(action))
         acsr_pkg::ACSR_TOUCH_DUMMY: onehot = 4'h1;
         acsr_pkg::ACSR_TOUCH_X: onehot = 4'h2;
         acsr_pkg::ACSR_TOUCH_Y: onehot = 4'h4;
         acsr_pkg::ACSR_TOUCH_CONTACT: onehot = 4'h8;
         default: onehot = 4'h1;
      endcase
   end
endmodule

module acsr_top (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [23:0] reg_wdata,
   output logic [23:0] reg_rdata,
   output logic reg_rvalid,
   // converter core result strobe
   input wire logic conv_done,
   input wire logic [1:0] conv_slot,
   input wire logic [9:0] conv_value,
   // selections toward converter and touch panel
   output logic [3:0] slot6_channel_select,
   output logic [3:0] slot7_channel_select,
   output logic [15:0] slot_touch_action,
   output logic [31:0] slot_touch_onehot
);
   typedef struct packed {
      logic [23:0] sel;
      logic [23:0] rdata;
      logic rvalid;
      logic [31:0] onehot;
   } acsr_top_t;
   acsr_top_t state;
   acsr_top_t next_state;
   logic [39:0] results;
   logic [31:0] onehot_w;

   // pack two results into a 24-bit word, gaps read zero
   function automatic logic [23:0] pack_pair(input logic [9:0] lo, input logic [9:0] hi);
      logic [23:0] w;
      w = '0;
      w[acsr_pkg::RES_LO_LSB +: acsr_pkg::RES_W] = lo;
      w[acsr_pkg::RES_HI_LSB +: acsr_pkg::RES_W] = hi;
      return w;
   endfunction

   // ------------------------------------------------------------------
   // result memory
   // ------------------------------------------------------------------
   acsr_result_store #(
      .DEPTH(acsr_pkg::RESULTS),
      .WIDTH(acsr_pkg::RES_W)
   ) u_store (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .wr_en(conv_done),
      .wr_idx(conv_slot),
      .wr_data(conv_value),
      .rd_all(results)
   );

   // ------------------------------------------------------------------
   // touch action decode per slot
   // ------------------------------------------------------------------
   for (genvar i = 0; i < acsr_pkg::SLOTS; i++) begin : g_dec
      acsr_touch_decode u_dec (
         .action(state.sel[acsr_pkg::TACT0_LSB + 2*i +: acsr_pkg::TACT_W]),
         .onehot(onehot_w[4*i +: 4])
      );
   end

   // register write, read mux
   always_comb begin
      next_state = state;
      next_state.rvalid = reg_rd;
      next_state.onehot = onehot_w;
      // only the select register accepts writes; result addresses drop them
      if (reg_wr && reg_addr == acsr_pkg::ADDR_SLOT_SELECT) begin
         next_state.sel = reg_wdata;
      end
      if (reg_rd) begin
         case (reg_addr)
            acsr_pkg::ADDR_SLOT_SELECT: next_state.rdata = state.sel;
            acsr_pkg::ADDR_RESULT_A: next_state.rdata = pack_pair(results[0 +: 10], results[10 +: 10]);
            acsr_pkg::ADDR_RESULT_B: next_state.rdata = pack_pair(results[20 +: 10], results[30 +: 10]);
            default: next_state.rdata = '0; // unmapped reads give zero
         endcase
      end
   end

   // all state clears on digital reset
   always_ff @(posedge core_clk or negedge rst_n) begin
      if (!rst_n) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   // outputs straight from flops
   assign reg_rdata = state.rdata;
   assign reg_rvalid = state.rvalid;
   assign slot6_channel_select = state.sel[acsr_pkg::SEL6_LSB +: acsr_pkg::CHAN_W];
   assign slot7_channel_select = state.sel[acsr_pkg::SEL7_LSB +: acsr_pkg::CHAN_W];
   assign slot_touch_action = state.sel[acsr_pkg::TACT0_LSB +: 16];
   assign slot_touch_onehot = state.onehot;
endmodule

/* File: acsr_top_asserts.sv */
/* port checker for acsr_top.
   assumes one clock, async active-low reset. */
`timescale 1ns/100ps
module acsr_top_asserts (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // register port
   input wire logic [5:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [23:0] reg_wdata,
   input wire logic [23:0] reg_rdata,
   input wire logic reg_rvalid,
   // converter strobe
   input wire logic conv_done,
   input wire logic [1:0] conv_slot,
   input wire logic [9:0] conv_value,
   // selections
   input wire logic [3:0] slot6_channel_select,
   input wire logic [3:0] slot7_channel_select,
   input wire logic [15:0] slot_touch_action,
   input wire logic [31:0] slot_touch_onehot
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!rst_n);
   // decoded accesses
   wire wr_sel = reg_wr && reg_addr == acsr_pkg::ADDR_SLOT_SELECT;
   wire rd_a = reg_rd && reg_addr == acsr_pkg::ADDR_RESULT_A;
   wire rd_res = rd_a || (reg_rd && reg_addr == acsr_pkg::ADDR_RESULT_B);
   a_sel6_write: assert property (wr_sel |=> slot6_channel_select == $past(reg_wdata[3:0]))
      else $error("slot6 select");
   a_sel7_write: assert property (wr_sel |=> slot7_channel_select == $past(reg_wdata[7:4]))
      else $error("slot7 select");
   a_touch_write: assert property (wr_sel |=> slot_touch_action == $past(reg_wdata[23:8]))
      else $error("touch field");
   // onehot lags the field by a cycle, so skip the edge right after reset
   a_onehot_first: assert property ($past(rst_n) |-> slot_touch_onehot[3:0] == 4'h1 << $past(slot_touch_action[1:0]))
      else $error("slot0 decode");
   a_onehot_last: assert property ($past(rst_n) |-> slot_touch_onehot[31:28] == 4'h1 << $past(slot_touch_action[15:14]))
      else $error("slot7 decode");
   a_rd_select: assert property (reg_rd && reg_addr == acsr_pkg::ADDR_SLOT_SELECT |=>
      reg_rdata == $past({slot_touch_action, slot7_channel_select, slot6_channel_select})) else $error("select read");
   a_unused_zero: assert property (rd_res |=> reg_rdata[1:0] == 2'h0 && reg_rdata[13:12] == 2'h0)
      else $error("unused bits");
   a_rvalid_pulse: assert property ($past(rst_n) |-> reg_rvalid == $past(reg_rd))
      else $error("rvalid timing");
   // the store is written one edge after the strobe and the read data land three edges after that
   a_slot0_result: assert property (conv_done && conv_slot == 2'h0 ##1 !conv_done [*2] ##1 rd_a && !conv_done |=>
      reg_rdata[11:2] == $past(conv_value, 4)) else $error("slot0 result");
   c_wr_sel: cover property (wr_sel);
   c_rd_res: cover property (rd_res);
   c_contact: cover property (slot_touch_action[15:14] == 2'h3);
endmodule

/* File: acsr_conv_model.sv */
/* converter core stand-in: one result strobe per put call.
   assumes calls come after reset on core_clk. */
`timescale 1ns/100ps
module acsr_conv_model (
   // clock
   input wire logic core_clk,
   // result strobe
   output logic conv_done = 1'b0,
   output logic [1:0] conv_slot = 2'h0,
   output logic [9:0] conv_value = 10'h000
);
   // value scrambled off the strobe so a stale sample cannot pass
   task put(input logic [1:0] s, input logic [9:0] v);
      @(posedge core_clk) begin
         conv_done <= 1'b1;
         conv_slot <= s;
         conv_value <= v;
      end
      @(posedge core_clk) conv_done <= 1'b0;
      conv_value <= ~v;
   endtask
endmodule

/* File: acsr_top_test.sv */
/* self-checking bench for acsr_top.
   assumes read data one cycle after the strobe. */
`timescale 1ns/100ps
module acsr_top_test;
   logic core_clk, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, reg_rvalid, conv_done;
   logic [5:0] reg_addr = 6'h00;
   logic [23:0] reg_wdata = 24'h000000, reg_rdata;
   logic [1:0] conv_slot;
   logic [9:0] conv_value;
   logic [3:0] s6, s7;
   logic [15:0] ta;
   logic [31:0] oh;
   int n_mismatch = 0;
   int total_checks = 0;
   acsr_top uut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
      .conv_slot(conv_slot), .conv_value(conv_value), .slot6_channel_select(s6), .slot7_channel_select(s7),
      .slot_touch_action(ta), .slot_touch_onehot(oh));
   acsr_conv_model conv (.core_clk(core_clk), .conv_done(conv_done), .conv_slot(conv_slot), .conv_value(conv_value));
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end
   task chk(input string n, input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         $display("[ERR] %s expected %h seen %h", n, e, s);
         n_mismatch++;
      end
   endtask
   task acc(input logic w, input logic [5:0] a, input logic [23:0] d);
      @(posedge core_clk) begin
         reg_addr <= a;
         reg_wdata <= d;
         reg_wr <= w;
         reg_rd <= !w;
      end
      @(posedge core_clk) {reg_wr, reg_rd} <= 2'h0;
      #1 if (!w) chk("read", {reg_rvalid, reg_rdata}, {1'b1, d});
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   // main sequence: reset values, selections, results, refused writes, reset again
   initial begin
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(0, 6'h2E, 24'h000000);
      acc(0, 6'h2F, 24'h000000);
      acc(0, 6'h3F, 24'h000000);
      acc(1, 6'h2E, 24'hE4E4A5);
      acc(0, 6'h2E, 24'hE4E4A5);
      chk("onehot", oh, 32'h84218421);
      acc(1, 6'h2E, 24'h1B1B5A);
      chk("select", {ta, s7, s6}, 24'h1B1B5A);
      conv.put(2'h1, 10'h155);
      conv.put(2'h2, 10'h2AA);
      conv.put(2'h3, 10'h001);
      conv.put(2'h0, 10'h3FF);
      acc(0, 6'h2F, {10'h155, 2'h0, 10'h3FF, 2'h0});
      chk("onehot", oh, 32'h12481248);
      acc(1, 6'h2F, 24'hFFFFFF);
      acc(1, 6'h30, 24'h000000);
      acc(0, 6'h30, {10'h001, 2'h0, 10'h2AA, 2'h0});
      acc(0, 6'h2F, {10'h155, 2'h0, 10'h3FF, 2'h0});
      @(posedge core_clk) rst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      rst_n <= 1'b1;
      acc(0, 6'h2E, 24'h000000);
      acc(0, 6'h30, 24'h000000);
      test_done;
   end
   // watchdog well past the thirty-nine cycles the sequence needs
   initial begin
      #20000;
      n_mismatch++;
      test_done;
   end
endmodule
bind acsr_top acsr_top_asserts chk_i (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
   .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .conv_done(conv_done),
   .conv_slot(conv_slot), .conv_value(conv_value), .slot6_channel_select(slot6_channel_select),
   .slot7_channel_select(slot7_channel_select), .slot_touch_action(slot_touch_action),
   .slot_touch_onehot(slot_touch_onehot));
